//--- common/crf_pkg.sv
/*
 Package for the RAM fault event flag block: register offsets, flag bit
 positions, reset values and the carrier structs shared by the design files.
 Assumes a 32-bit APB register bus and one 50 MHz clock.
*/
package crf_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] CRF_EVENT_FLAGS_OFFSET = 12'h050;
	localparam logic [11:0] CRF_CORE_CONTROL_OFFSET = 12'h018;
	localparam logic [11:0] CRF_HANDLER_STATUS_OFFSET = 12'h054;

	// ----------------------------------------------------------------
	// Flag bit positions in the event flag register
	// ----------------------------------------------------------------
	localparam int CRF_BIT_ERROR_FIXED_POS = 20;
	localparam int CRF_BUFFER_STORED_POS = 19;
	localparam int CRF_TIME_LIMIT_POS = 18;
	localparam int CRF_ACCESS_FAILURE_POS = 17;
	localparam int CRF_TIMESTAMP_WRAP_POS = 16;
	localparam int CRF_FLAG_LOW_POS = 16;
	localparam int CRF_FLAG_COUNT = 5;

	// Restricted operation bit in the core control register
	localparam int CRF_RESTRICTED_POS = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] CRF_FLAGS_RESET = 5'h00;
	localparam logic [31:0] CRF_CORE_CONTROL_RESET = 32'h00000000;
	localparam logic [31:0] CRF_READ_ZERO = 32'h00000000;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} crf_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} crf_apb_rsp_type;

	// One-cycle pulses from the receive and transmit handlers
	typedef struct packed {
		logic [1:0] ramError;
		logic ramRead;
		logic bufferStore;
		logic timeLimitHit;
		logic nextArbDone;
		logic storeWriteFail;
		logic txFetchLate;
		logic timestampWrap;
	} crf_event_in_type;

	// Receive storage job as seen by the flag block
	typedef struct packed {
		logic start;
		logic finish;
		logic toFifo;
	} crf_rx_job_type;

	typedef enum logic [2:0] {
		CRF_RX_IDLE = 3'b001,
		CRF_RX_BUSY = 3'b010,
		CRF_RX_ABORT = 3'b100
	} crf_rx_state_type;

endpackage

//--- verilog/crf_sticky_flags.sv
/*
 Sticky flag bank: each bit set by its event pulse, cleared by writing 1.
 Assumes set and clear pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
module crf_sticky_flags
	import crf_pkg::*;
#(
	parameter int WIDTH = CRF_FLAG_COUNT
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Events and clears
	input wire logic [WIDTH-1:0] setPulse,
	input wire logic [WIDTH-1:0] clearPulse,
	// Flag state
	output logic [WIDTH-1:0] flags
);

	// Refuse a bank with no flags at elaboration
	if (WIDTH < 1) begin : gBadWidth
		$error("crf_sticky_flags: WIDTH must be at least 1");
	end

	// ----------------------------------------------------------------
	// One sticky bit per flag; a set in the clear cycle wins
	// ----------------------------------------------------------------
	for (genvar i = 0; i < WIDTH; i++) begin : gFlag
		always_ff @(posedge clk) begin
			if (reset) begin
				flags[i] <= 1'b0;
			end else if (setPulse[i]) begin
				flags[i] <= 1'b1;
			end else if (clearPulse[i]) begin
				flags[i] <= 1'b0;
			end
		end
	end

endmodule

//--- verilog/crf_apb_slave.sv
/*
 APB slave front end: decodes one transfer per access phase, answers with
 zero wait states, flags unmapped addresses with pslverr.
 Assumes the master keeps request signals steady through the access phase.
*/
`timescale 1ns/1ps
module crf_apb_slave
	import crf_pkg::*;
(
	// Bus
	input wire crf_apb_req_type apbReq,
	output crf_apb_rsp_type apbRsp,
	// Register side
	input wire logic [31:0] readData,
	input wire logic addrHit,
	output logic writeStrobe,
	output logic [11:0] regAddr,
	output logic [31:0] regWdata
);

	// Access phase handshake, no wait states
	assign writeStrobe = apbReq.psel & apbReq.penable & apbReq.pwrite & addrHit;
	assign regAddr = apbReq.paddr;
	assign regWdata = apbReq.pwdata;
	assign apbRsp.pready = 1'b1;
	assign apbRsp.pslverr = apbReq.psel & apbReq.penable & ~addrHit;
	assign apbRsp.prdata = (apbReq.psel & ~apbReq.pwrite & addrHit) ? readData : CRF_READ_ZERO;

endmodule

//--- verilog/crf_event_flags.sv
/*
 RAM fault event flags of the CAN FD controller: corrected bit error,
 dedicated buffer stored, timeout, RAM access failure, timestamp wrap.
 Also holds the receive storage abort tracking and restricted operation.
 Assumes handler event inputs are one-cycle pulses on clk.
*/
// Function
// - Set corrected bit error flag, bit 20, on checker error bit zero during read.
// - Bit 20 one means corrected RAM error seen, zero means none.
// - Set buffer stored flag, bit 19, on each dedicated buffer store.
// - Set timeout flag, bit 18, on timeout; zero otherwise.
// - Set access failure flag, bit 17, when filtering overruns next arbitration field.
// - On overrun, abandon unfinished filtering or storage, start next message.
// - Set access failure flag and abort storage when RAM write fails.
// - Aborted storage leaves put index and new data indication untouched.
// - Partial message gets overwritten by next store to same location.
// - Set access failure flag when transmit fetch comes too late.
// - Abort transmission of a message fetched too late.
// - Transmit access failure forces restricted operation until bit cleared.
// - Set timestamp wrap flag, bit 16, on counter wrap; zero otherwise.
`timescale 1ns/1ps
module crf_event_flags
	import crf_pkg::*;
#(
	parameter int PUT_INDEX_WIDTH = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// APB
	input wire crf_apb_req_type apbReq,
	output crf_apb_rsp_type apbRsp,
	// Handler events
	input wire crf_event_in_type events,
	input wire crf_rx_job_type rxJob,
	// Receive storage results
	output logic rxStoreAbort,
	output logic putIndexAdvance,
	output logic newDataSet,
	output logic [PUT_INDEX_WIDTH-1:0] putIndex,
	// Transmit and mode
	output logic txAbort,
	output logic restrictedOperation
);

	// Refuse put index widths that the status word cannot hold
	if (PUT_INDEX_WIDTH < 1 || PUT_INDEX_WIDTH > 16) begin : gBadIndexWidth
		$error("crf_event_flags: PUT_INDEX_WIDTH out of range");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	crf_rx_state_type rxState;
	crf_rx_state_type next_rxState;
	logic [CRF_FLAG_COUNT-1:0] flags;
	logic [CRF_FLAG_COUNT-1:0] setPulse;
	logic [CRF_FLAG_COUNT-1:0] clearPulse;
	logic [31:0] coreControl;
	logic [31:0] readData;
	logic [31:0] flagWord;
	logic [31:0] statusWord;
	logic addrHit;
	logic writeStrobe;
	logic [11:0] regAddr;
	logic [31:0] regWdata;
	logic rxOverrun;
	logic rxFail;
	logic rxGoodFinish;
	logic accessFailure;
	logic bitErrorFixed;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	crf_apb_slave uApb (
		.apbReq(apbReq),
		.apbRsp(apbRsp),
		.readData(readData),
		.addrHit(addrHit),
		.writeStrobe(writeStrobe),
		.regAddr(regAddr),
		.regWdata(regWdata)
	);

	// Address decode
	assign addrHit = (apbReq.paddr == CRF_EVENT_FLAGS_OFFSET)
		| (apbReq.paddr == CRF_CORE_CONTROL_OFFSET)
		| (apbReq.paddr == CRF_HANDLER_STATUS_OFFSET);

	// Read data mux; in the flag word, bits outside the flag field read zero
	always_comb begin
		flagWord = CRF_READ_ZERO;
		flagWord[CRF_FLAG_LOW_POS +: CRF_FLAG_COUNT] = flags;
		statusWord = CRF_READ_ZERO;
		statusWord[2:0] = rxState;
		statusWord[16 +: PUT_INDEX_WIDTH] = putIndex;
		case (regAddr)
			CRF_EVENT_FLAGS_OFFSET: begin
				readData = flagWord;
			end
			CRF_CORE_CONTROL_OFFSET: begin
				readData = coreControl;
			end
			CRF_HANDLER_STATUS_OFFSET: begin
				readData = statusWord;
			end
			default: begin
				readData = CRF_READ_ZERO;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Receive storage tracking
	// ----------------------------------------------------------------
	// Overrun: next arbitration field done while job still open
	assign rxOverrun = (rxState == CRF_RX_BUSY) & events.nextArbDone & ~rxJob.finish;
	assign rxFail = (rxState == CRF_RX_BUSY) & events.storeWriteFail;
	assign rxGoodFinish = (rxState == CRF_RX_BUSY) & rxJob.finish & ~events.storeWriteFail;

	// State update
	always_ff @(posedge clk) begin
		if (reset) begin
			rxState <= CRF_RX_IDLE;
		end else begin
			rxState <= next_rxState;
		end
	end

	// Next state: an overrun drops the job and takes the new message at once
	always_comb begin
		next_rxState = rxState;
		case (rxState)
			CRF_RX_IDLE: begin
				if (rxJob.start) begin
					next_rxState = CRF_RX_BUSY;
				end
			end
			CRF_RX_BUSY: begin
				if (rxFail) begin
					next_rxState = CRF_RX_ABORT;
				end else if (rxOverrun) begin
					next_rxState = CRF_RX_BUSY;
				end else if (rxJob.finish) begin
					next_rxState = CRF_RX_IDLE;
				end
			end
			CRF_RX_ABORT: begin
				next_rxState = rxJob.start ? CRF_RX_BUSY : CRF_RX_IDLE;
			end
			default: begin
				next_rxState = CRF_RX_IDLE;
			end
		endcase
	end

	// Abort pulse to the receive handler; the slot stays for reuse
	assign rxStoreAbort = rxOverrun | rxFail;

	// Only a completed store advances the index or sets new data
	assign putIndexAdvance = rxGoodFinish & ~rxOverrun & rxJob.toFifo;
	assign newDataSet = rxGoodFinish & ~rxOverrun & ~rxJob.toFifo;

	// FIFO put index, untouched by aborted stores
	always_ff @(posedge clk) begin
		if (reset) begin
			putIndex <= '0;
		end else if (putIndexAdvance) begin
			putIndex <= putIndex + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Transmit failure and restricted operation
	// ----------------------------------------------------------------
	assign txAbort = events.txFetchLate;

	// Core control: host writes; late fetch forces restricted bit, set wins
	always_ff @(posedge clk) begin
		if (reset) begin
			coreControl <= CRF_CORE_CONTROL_RESET;
		end else begin
			if (writeStrobe && regAddr == CRF_CORE_CONTROL_OFFSET) begin
				coreControl <= regWdata;
			end
			if (events.txFetchLate) begin
				coreControl[CRF_RESTRICTED_POS] <= 1'b1;
			end
		end
	end

	assign restrictedOperation = coreControl[CRF_RESTRICTED_POS];

	// ----------------------------------------------------------------
	// Flag events
	// ----------------------------------------------------------------
	// Only a corrected error seen during a read counts; the uncorrected bit is not ours
	assign bitErrorFixed = events.ramRead & events.ramError[0];
	assign accessFailure = rxOverrun | rxFail | events.txFetchLate;

	always_comb begin
		setPulse = '0;
		setPulse[CRF_BIT_ERROR_FIXED_POS - CRF_FLAG_LOW_POS] = bitErrorFixed;
		setPulse[CRF_BUFFER_STORED_POS - CRF_FLAG_LOW_POS] = events.bufferStore;
		setPulse[CRF_TIME_LIMIT_POS - CRF_FLAG_LOW_POS] = events.timeLimitHit;
		setPulse[CRF_ACCESS_FAILURE_POS - CRF_FLAG_LOW_POS] = accessFailure;
		setPulse[CRF_TIMESTAMP_WRAP_POS - CRF_FLAG_LOW_POS] = events.timestampWrap;
	end

	// Write one to clear
	always_comb begin
		clearPulse = '0;
		if (writeStrobe && regAddr == CRF_EVENT_FLAGS_OFFSET) begin
			clearPulse = regWdata[CRF_FLAG_LOW_POS +: CRF_FLAG_COUNT];
		end
	end

	crf_sticky_flags #(
		.WIDTH(CRF_FLAG_COUNT)
	) uFlags (
		.clk(clk),
		.reset(reset),
		.setPulse(setPulse),
		.clearPulse(clearPulse),
		.flags(flags)
	);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	bit_error_set_a: assert property (@(posedge clk) disable iff (reset)
		bitErrorFixed |=> flags[CRF_BIT_ERROR_FIXED_POS - CRF_FLAG_LOW_POS])
		else $error("corrected bit error flag not set");
	bit_error_cause_a: assert property (@(posedge clk) disable iff (reset)
		$rose(flags[4]) |-> $past(events.ramRead & events.ramError[0]))
		else $error("bit error flag rose without a corrected error");
	buffer_stored_a: assert property (@(posedge clk) disable iff (reset)
		events.bufferStore |=> flags[3])
		else $error("buffer stored flag not set");
	timeout_flag_a: assert property (@(posedge clk) disable iff (reset)
		$rose(flags[2]) |-> $past(events.timeLimitHit))
		else $error("timeout flag rose without timeout");
	overrun_fail_a: assert property (@(posedge clk) disable iff (reset)
		rxOverrun |-> rxStoreAbort ##1 flags[1])
		else $error("overrun did not abort and flag");
	overrun_restart_a: assert property (@(posedge clk) disable iff (reset)
		rxOverrun && !rxFail |=> rxState == CRF_RX_BUSY)
		else $error("overrun did not start next message");
	write_fail_a: assert property (@(posedge clk) disable iff (reset)
		rxFail |=> rxState == CRF_RX_ABORT && flags[1])
		else $error("write failure not handled");
	abort_no_index_a: assert property (@(posedge clk) disable iff (reset)
		rxStoreAbort |-> !putIndexAdvance && !newDataSet ##1 putIndex == $past(putIndex))
		else $error("aborted store moved index or set new data");
	tx_late_a: assert property (@(posedge clk) disable iff (reset)
		events.txFetchLate |-> txAbort ##1 flags[1])
		else $error("late fetch not flagged");
	restricted_hold_a: assert property (@(posedge clk) disable iff (reset)
		restrictedOperation && !(writeStrobe && regAddr == CRF_CORE_CONTROL_OFFSET)
		|=> restrictedOperation)
		else $error("restricted operation left without host write");
	wrap_flag_a: assert property (@(posedge clk) disable iff (reset)
		events.timestampWrap |=> flags[0])
		else $error("timestamp wrap flag not set");
	sticky_hold_a: assert property (@(posedge clk) disable iff (reset)
		flags[0] && !clearPulse[0] |=> flags[0])
		else $error("wrap flag dropped without a clear");

	// Set, cause, leave and abort return checks
	timeout_set_a: assert property (@(posedge clk) disable iff (reset)
		events.timeLimitHit |=> flags[2])
		else $error("timeout flag not set");
	buffer_cause_a: assert property (@(posedge clk) disable iff (reset)
		$rose(flags[3]) |-> $past(events.bufferStore))
		else $error("buffer stored flag rose without a store");
	failure_cause_a: assert property (@(posedge clk) disable iff (reset)
		$rose(flags[1]) |-> $past(rxOverrun || rxFail || events.txFetchLate))
		else $error("access failure flag rose without a failure");
	wrap_cause_a: assert property (@(posedge clk) disable iff (reset)
		$rose(flags[0]) |-> $past(events.timestampWrap))
		else $error("wrap flag rose without a wrap");
	restricted_set_a: assert property (@(posedge clk) disable iff (reset)
		events.txFetchLate |=> restrictedOperation)
		else $error("late fetch did not force restricted operation");
	restricted_leave_a: assert property (@(posedge clk) disable iff (reset)
		writeStrobe && regAddr == CRF_CORE_CONTROL_OFFSET && !regWdata[CRF_RESTRICTED_POS]
		&& !events.txFetchLate |=> !restrictedOperation)
		else $error("restricted operation kept after host clear");
	abort_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
		rxState == CRF_RX_ABORT && !rxJob.start |=> rxState == CRF_RX_IDLE)
		else $error("abort state did not return to idle");

	// Main scenarios
	cov_overrun: cover property (@(posedge clk) disable iff (reset) rxOverrun);
	cov_write_fail: cover property (@(posedge clk) disable iff (reset) rxFail);
	cov_restricted: cover property (@(posedge clk) disable iff (reset)
		events.txFetchLate ##[1:20] !restrictedOperation);
	cov_clear: cover property (@(posedge clk) disable iff (reset) |clearPulse);
	cov_good_store: cover property (@(posedge clk) disable iff (reset) putIndexAdvance);

endmodule

//--- verification/crf_handler_model.sv
/*
 Handler model: turns the bench's request word into registered event and
 receive job pulses, as the receive and transmit handlers would send them.
 Assumes the bench changes the request right after a rising edge.
*/
`timescale 1ns/1ps
module crf_handler_model
	import crf_pkg::*;
(
	// Clock
	input wire logic clk,
	// Request from the bench
	input wire logic [11:0] pulseReq,
	// Pulses to the flag block
	output crf_event_in_type events,
	output crf_rx_job_type rxJob
);
	// Register the request; each pulse lasts as many cycles as the bench holds the request
	always_ff @(posedge clk) begin
		events <= crf_event_in_type'(pulseReq[8:0]);
		rxJob <= crf_rx_job_type'(pulseReq[11:9]);
	end
endmodule

//--- verification/test_crf_event_flags.sv
/*
 Self-checking bench for the RAM fault event flags: APB master tasks,
 event pulses through the handler model, one task per scenario.
 Assumes zero-wait APB answers and one 50 MHz clock.
*/
`timescale 1ns/1ps
module test_crf_event_flags;
	import crf_pkg::*;
	localparam logic [11:0] FLG = CRF_EVENT_FLAGS_OFFSET;
	localparam logic [11:0] CORE = CRF_CORE_CONTROL_OFFSET;
	localparam logic [11:0] E_TXLATE = 12'h002, E_FAIL = 12'h004, E_ARB = 12'h008;
	localparam logic [11:0] E_READ = 12'h040, E_ERR0 = 12'h080, E_ERR1 = 12'h100;
	localparam logic [11:0] J_FIFO = 12'h200, J_FIN = 12'h400, J_START = 12'h800;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [11:0] pulseReq = 12'h000;
	crf_apb_req_type apbReq = '0;
	crf_apb_rsp_type apbRsp;
	crf_event_in_type events;
	crf_rx_job_type rxJob;
	logic rxStoreAbort, putIndexAdvance, newDataSet, txAbort, restrictedOperation;
	logic [5:0] putIndex;
	logic [31:0] rdData;
	logic rdErr;
	int miscompares = 0;
	int checksDone = 0;

	// ----------------------------------------------------------------
	// Design and handler model
	// ----------------------------------------------------------------
	crf_event_flags #(.PUT_INDEX_WIDTH(6)) u_dut (.clk(clk), .reset(reset),
		.apbReq(apbReq), .apbRsp(apbRsp), .events(events), .rxJob(rxJob),
		.rxStoreAbort(rxStoreAbort), .putIndexAdvance(putIndexAdvance),
		.newDataSet(newDataSet), .putIndex(putIndex), .txAbort(txAbort),
		.restrictedOperation(restrictedOperation));
	crf_handler_model u_model (.clk(clk), .pulseReq(pulseReq), .events(events),
		.rxJob(rxJob));

	// Free running clock, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d miscompares %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checksDone++;
		if (got !== ex) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One APB transfer; read data and error taken at the completing edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge clk);
		apbReq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 50);
		rdData = apbRsp.prdata;
		rdErr = apbRsp.pslverr;
		apbReq <= '0;
		if (n >= 50) begin
			miscompares++;
			results();
		end
	endtask

	// Pulse is live in the cycle the task returns in; comb outputs settle there
	task automatic fire(input logic [11:0] p);
		@(posedge clk);
		pulseReq <= p;
		@(posedge clk);
		pulseReq <= 12'h000;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic testFlags();
		logic [11:0] ev [4];
		int ps [4];
		ev = '{E_READ | E_ERR0, 12'h020, 12'h010, 12'h001};
		ps = '{CRF_BIT_ERROR_FIXED_POS, CRF_BUFFER_STORED_POS, CRF_TIME_LIMIT_POS,
			CRF_TIMESTAMP_WRAP_POS};
		apb(FLG, 1'b0, 32'h0);
		chk("flags after reset", 32'h0, rdData);
		fire(E_ERR0);
		fire(E_READ | E_ERR1);
		apb(FLG, 1'b0, 32'h0);
		chk("no corrected error", 32'h0, rdData);
		for (int i = 0; i < 4; i++) begin
			fire(ev[i]);
			apb(FLG, 1'b0, 32'h0);
			chk("flag set", 32'h1 << ps[i], rdData);
			apb(FLG, 1'b1, 32'h0);
			apb(FLG, 1'b0, 32'h0);
			chk("flag held", 32'h1 << ps[i], rdData);
			apb(FLG, 1'b1, 32'h1 << ps[i]);
			apb(FLG, 1'b0, 32'h0);
			chk("flag cleared", 32'h0, rdData);
		end
		$display("test flags done");
	endtask

	task automatic testOverrun();
		fire(J_START);
		fire(E_ARB);
		chk("overrun abort", 32'h1, 32'(rxStoreAbort));
		chk("overrun advance", 32'h0, 32'(putIndexAdvance));
		apb(FLG, 1'b0, 32'h0);
		chk("overrun flag", 32'h1 << CRF_ACCESS_FAILURE_POS, rdData);
		apb(FLG, 1'b1, 32'h1 << CRF_ACCESS_FAILURE_POS);
		fire(J_FIN | J_FIFO);
		chk("next message advance", 32'h1, 32'(putIndexAdvance));
		@(posedge clk);
		#1;
		chk("put index", 32'h1, 32'(putIndex));
		$display("test overrun done");
	endtask

	task automatic testFail();
		fire(J_START);
		fire(E_FAIL);
		chk("fail abort", 32'h1, 32'(rxStoreAbort));
		chk("fail new data", 32'h0, 32'(newDataSet));
		chk("fail advance", 32'h0, 32'(putIndexAdvance));
		apb(FLG, 1'b0, 32'h0);
		chk("fail flag", 32'h1 << CRF_ACCESS_FAILURE_POS, rdData);
		apb(FLG, 1'b1, 32'h1 << CRF_ACCESS_FAILURE_POS);
		fire(J_START);
		fire(J_FIN);
		chk("rewrite new data", 32'h1, 32'(newDataSet));
		@(posedge clk);
		#1;
		chk("put index kept", 32'h1, 32'(putIndex));
		$display("test fail done");
	endtask

	task automatic testTx();
		fire(E_TXLATE);
		chk("tx abort", 32'h1, 32'(txAbort));
		repeat (6) @(posedge clk);
		#1;
		chk("restricted held", 32'h1, 32'(restrictedOperation));
		apb(FLG, 1'b0, 32'h0);
		chk("tx flag", 32'h1 << CRF_ACCESS_FAILURE_POS, rdData);
		apb(CORE, 1'b0, 32'h0);
		chk("core restricted", 32'h1 << CRF_RESTRICTED_POS, rdData);
		apb(CORE, 1'b1, 32'h0);
		apb(CORE, 1'b0, 32'h0);
		chk("core cleared", 32'h0, rdData);
		chk("restricted left", 32'h0, 32'(restrictedOperation));
		$display("test tx done");
	endtask

	task automatic testUnmapped();
		apb(12'h0FC, 1'b1, 32'hFFFFFFFF);
		apb(12'h0FC, 1'b0, 32'h0);
		chk("unmapped error", 32'h1, 32'(rdErr));
		chk("unmapped data", CRF_READ_ZERO, rdData);
		apb(FLG, 1'b0, 32'h0);
		chk("flags kept", 32'h1 << CRF_ACCESS_FAILURE_POS, rdData);
		$display("test unmapped done");
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		testFlags();
		testOverrun();
		testFail();
		testTx();
		testUnmapped();
		results();
	end
endmodule
